//--- verilog/tanc_nvm_defs.svh
`ifndef TANC_NVM_DEFS_SVH
`define TANC_NVM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TANC_OFF_CTRL   8'h00
`define TANC_OFF_UNLOCK 8'h04
`define TANC_OFF_LATCH  8'h08
`define TANC_OFF_PTRL   8'h0C
`define TANC_OFF_PTRH   8'h10
`define TANC_OFF_PTRU   8'h14
`define TANC_OFF_CMD    8'h18
`define TANC_OFF_STAT   8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TANC_B_SPACE    7
`define TANC_B_CFG      6
`define TANC_B_ERASE    4
`define TANC_B_FAULT    3
`define TANC_B_PERMIT   2
`define TANC_B_LAUNCH   1
`define TANC_B_FETCH    0
`define TANC_B_DONE     0
`define TANC_B_BUSY     1
`define TANC_B_STORE    2
`define TANC_ERASE_LSB  6

// ----------------------------------------------------------------
// values and timing
// ----------------------------------------------------------------
`define TANC_KEY_FIRST  8'h55
`define TANC_KEY_SECOND 8'hAA
`define TANC_HOLD_RST   8'hFF
`define TANC_HOLD_BYTES 64
`define TANC_PTR_W      22
`define TANC_CLK_MHZ    250
`define TANC_CYC_TIME_US 2000

`endif

//--- verilog/tanc_pkg.sv
package tanc_pkg;

  // ----------------------------------------------------------------
  // pointer update modes, space targets, fetch states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TANC_KEEP,
    TANC_POST_INC,
    TANC_POST_DEC,
    TANC_PRE_INC
  } tanc_mode_type;

  typedef enum logic [1:0] {
    TANC_SP_EE,
    TANC_SP_FLASH,
    TANC_SP_CFG
  } tanc_space_type;

  typedef enum logic {
    TANC_TBL_IDLE,
    TANC_TBL_FETCH
  } tanc_tbl_state_type;

endpackage : tanc_pkg

//--- verilog/tanc_nvm_ctrl.sv
// Behaviour
// R1 - unlock port reads as all zeros
// R2 - bit 7 picks flash or eeprom
// R3 - bit 6 picks config space, overriding
// R4 - erase-arm bit selects erase, cleared when done
// R5 - modify permit gates cycles, reset cleared
// R6 - fault flag shows cut or improper cycle (presetn clears it, so a cycle cut by reset is not shown)
// R7 - launch sets fault, completion clears it
// R8 - launch set-only, hardware clears at end
// R9 - done flag sticky until firmware clears
// R10 - fetch bit one-cycle read, blocked by spaces
// R11 - fault leaves space selects untouched
// R12 - control bit 5 reads zero
// R13 - byte latch holds moved bytes
// R14 - pointer is 22 bits from three bytes
// R15 - four pointer updates on low 21 bits
// R16 - table fetch loads addressed byte to latch
// R17 - table store fills holding register by index
// R18 - write sends whole block at upper bits
// R19 - erase uses pointer bits 21 to 6
// R20 - pointer lsb picks word byte
// R21 - software unlocks with 55h then AAh
// R22 - holding registers reset to FFh
// R23 - core stalls during program memory cycle
// R24 - launch ignored while cycle runs
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "tanc_nvm_defs.svh"

module tanc_nvm_ctrl #(
  parameter int HOLD_BYTES = `TANC_HOLD_BYTES,
  parameter int CYC_CYCLES = `TANC_CYC_TIME_US * `TANC_CLK_MHZ
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output wire logic [31:0]             prdata,
  output wire logic                    pready,
  output wire logic                    pslverr,
  input  wire logic [15:0]             nvm_rdata,
  output wire logic [21:0]             nvm_addr,
  output wire logic                    nvm_fetch,
  output wire logic                    ee_read,
  output wire logic                    cyc_active,
  output wire logic                    cyc_erase,
  output wire logic [1:0]              cyc_space,
  output wire logic [21:0]             cyc_addr,
  output wire logic [HOLD_BYTES*8-1:0] hold_data,
  output wire logic                    cpu_stall
);

  localparam int HOLD_IDX = $clog2(HOLD_BYTES);
  localparam int CNT_W    = $clog2(CYC_CYCLES + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0]                  prdata_ff;
  logic                         pready_ff, pslverr_ff, space_ff, cfg_ff, erase_ff, fault_ff;
  logic                         permit_ff, launch_ff, fetch_bit_ff, done_ff, stall_ff;
  logic                         cyc_erase_ff, nvm_fetch_ff;
  logic [1:0]                   unlk_ff;
  logic [CNT_W-1:0]             cnt_ff;
  tanc_pkg::tanc_space_type     cyc_space_ff;
  logic [21:0]                  cyc_addr_ff, ptr_ff, nvm_addr_ff;
  logic [7:0]                   latch_ff;
  tanc_pkg::tanc_tbl_state_type tbl_st_ff;
  logic [7:0]                   hold_ff [HOLD_BYTES];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                    acc, wr_ev, hit_ctrl, hit_unlk, hit_cmd, w_launch, launch_ok;
  logic                    cyc_done, hold_clr, tbl_go, st_ev, rd_err, nxt_pready;
  logic [21:0]             ptr_inc, ptr_dec, acc_addr, nxt_ptr;
  tanc_pkg::tanc_mode_type mode;
  logic [7:0]              ctrl_rd;
  logic [31:0]             rd_val;

  assign acc      = psel & penable;
  assign wr_ev    = acc & pready_ff & pwrite;
  assign hit_ctrl = wr_ev & (paddr == `TANC_OFF_CTRL);
  assign hit_unlk = wr_ev & (paddr == `TANC_OFF_UNLOCK);
  assign hit_cmd  = wr_ev & (paddr == `TANC_OFF_CMD);
  assign w_launch = hit_ctrl & pwdata[`TANC_B_LAUNCH] & ~launch_ff; // [R8] [R24]
  assign launch_ok = w_launch & permit_ff & (unlk_ff == 2'd2); // [R5] [R21]
  assign cyc_done = launch_ff & (cnt_ff == CNT_W'(1));
  assign hold_clr = cyc_done & ~cyc_erase_ff & (cyc_space_ff != tanc_pkg::TANC_SP_EE);

  assign ctrl_rd = {space_ff, cfg_ff, 1'b0, erase_ff, fault_ff, // [R12]
                    permit_ff, launch_ff, fetch_bit_ff};

  always_comb begin
    rd_val = 32'h0;
    rd_err = 1'b0;
    if (paddr == `TANC_OFF_CTRL) begin
      rd_val = {24'h0, ctrl_rd};
    end else if (paddr == `TANC_OFF_UNLOCK || paddr == `TANC_OFF_CMD) begin
      rd_val = 32'h0; // [R1]
    end else if (paddr == `TANC_OFF_LATCH) begin
      rd_val = {24'h0, latch_ff};
    end else if (paddr == `TANC_OFF_PTRL) begin
      rd_val = {24'h0, ptr_ff[7:0]};
    end else if (paddr == `TANC_OFF_PTRH) begin
      rd_val = {24'h0, ptr_ff[15:8]};
    end else if (paddr == `TANC_OFF_PTRU) begin
      rd_val = {26'h0, ptr_ff[21:16]};
    end else if (paddr == `TANC_OFF_STAT) begin
      rd_val = {30'h0, launch_ff | (tbl_st_ff != tanc_pkg::TANC_TBL_IDLE), done_ff};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // apb answer, one wait state, held off while the core is stalled
  // ----------------------------------------------------------------
  assign nxt_pready = acc & ~pready_ff & ~stall_ff; // [R23]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pready & rd_err;
      if (nxt_pready && !pwrite) begin
        prdata_ff <= rd_val;
      end else begin
        prdata_ff <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_ff  <= 1'b0;
      cfg_ff    <= 1'b0;
      permit_ff <= 1'b0; // [R5]
    end else if (hit_ctrl) begin
      space_ff  <= pwdata[`TANC_B_SPACE]; // [R2] [R11]
      cfg_ff    <= pwdata[`TANC_B_CFG]; // [R3]
      permit_ff <= pwdata[`TANC_B_PERMIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erase_ff <= 1'b0;
    end else if (cyc_done && cyc_erase_ff) begin
      erase_ff <= 1'b0; // [R4]
    end else if (hit_ctrl) begin
      erase_ff <= pwdata[`TANC_B_ERASE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 1'b0;
    end else if (w_launch) begin
      fault_ff <= 1'b1; // [R6] [R7]
    end else if (cyc_done) begin
      fault_ff <= 1'b0; // [R7]
    end else if (hit_ctrl) begin
      fault_ff <= pwdata[`TANC_B_FAULT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_bit_ff <= 1'b0;
    end else begin
      fetch_bit_ff <= hit_ctrl & pwdata[`TANC_B_FETCH] & // [R10]
                      ~pwdata[`TANC_B_SPACE] & ~pwdata[`TANC_B_CFG] &
                      ~space_ff & ~cfg_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlk_ff <= 2'd0;
    end else if (hit_unlk) begin
      if (pwdata[7:0] == `TANC_KEY_FIRST) begin
        unlk_ff <= 2'd1; // [R21]
      end else if (pwdata[7:0] == `TANC_KEY_SECOND && unlk_ff == 2'd1) begin
        unlk_ff <= 2'd2;
      end else begin
        unlk_ff <= 2'd0;
      end
    end else if (wr_ev) begin
      unlk_ff <= 2'd0;
    end
  end

  // ----------------------------------------------------------------
  // self-timed cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_ff <= 1'b0;
      cnt_ff    <= '0;
    end else if (launch_ok) begin
      launch_ff <= 1'b1; // [R8]
      cnt_ff    <= CNT_W'(CYC_CYCLES);
    end else if (launch_ff) begin
      launch_ff <= ~cyc_done; // [R8]
      cnt_ff    <= cnt_ff - CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_erase_ff <= 1'b0;
      cyc_space_ff <= tanc_pkg::TANC_SP_EE;
      cyc_addr_ff  <= 22'h0;
    end else if (launch_ok) begin
      cyc_erase_ff <= erase_ff & space_ff & ~cfg_ff; // [R4]
      if (cfg_ff) begin
        cyc_space_ff <= tanc_pkg::TANC_SP_CFG; // [R3]
      end else if (space_ff) begin
        cyc_space_ff <= tanc_pkg::TANC_SP_FLASH; // [R2]
      end else begin
        cyc_space_ff <= tanc_pkg::TANC_SP_EE;
      end
      if (erase_ff && space_ff && !cfg_ff) begin
        cyc_addr_ff <= {ptr_ff[21:`TANC_ERASE_LSB], 6'h0}; // [R19]
      end else if (space_ff || cfg_ff) begin
        cyc_addr_ff <= {ptr_ff[21:HOLD_IDX], HOLD_IDX'(0)}; // [R18]
      end else begin
        cyc_addr_ff <= ptr_ff;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_ff <= 1'b0;
    end else if (launch_ok) begin
      stall_ff <= space_ff | cfg_ff; // [R23]
    end else if (cyc_done) begin
      stall_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
    end else if (cyc_done) begin
      done_ff <= 1'b1; // [R9]
    end else if (wr_ev && paddr == `TANC_OFF_STAT && pwdata[`TANC_B_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // table pointer and latch
  // ----------------------------------------------------------------
  assign mode    = tanc_pkg::tanc_mode_type'(pwdata[1:0]);
  assign tbl_go  = hit_cmd & (tbl_st_ff == tanc_pkg::TANC_TBL_IDLE);
  assign st_ev   = tbl_go & pwdata[`TANC_B_STORE];
  assign ptr_inc = {ptr_ff[21], ptr_ff[20:0] + 21'h1}; // [R15]
  assign ptr_dec = {ptr_ff[21], ptr_ff[20:0] - 21'h1}; // [R15]

  always_comb begin
    acc_addr = ptr_ff;
    nxt_ptr  = ptr_ff;
    case (mode)
      tanc_pkg::TANC_POST_INC: nxt_ptr = ptr_inc;
      tanc_pkg::TANC_POST_DEC: nxt_ptr = ptr_dec;
      tanc_pkg::TANC_PRE_INC: begin
        nxt_ptr  = ptr_inc;
        acc_addr = ptr_inc;
      end
      default: nxt_ptr = ptr_ff;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff <= 22'h0;
    end else if (tbl_go) begin
      ptr_ff <= nxt_ptr; // [R15]
    end else if (wr_ev && paddr == `TANC_OFF_PTRL) begin
      ptr_ff[7:0] <= pwdata[7:0]; // [R14]
    end else if (wr_ev && paddr == `TANC_OFF_PTRH) begin
      ptr_ff[15:8] <= pwdata[7:0];
    end else if (wr_ev && paddr == `TANC_OFF_PTRU) begin
      ptr_ff[21:16] <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_st_ff    <= tanc_pkg::TANC_TBL_IDLE;
      nvm_fetch_ff <= 1'b0;
      nvm_addr_ff  <= 22'h0;
    end else begin
      case (tbl_st_ff)
        tanc_pkg::TANC_TBL_IDLE: begin
          if (tbl_go && !pwdata[`TANC_B_STORE]) begin
            tbl_st_ff    <= tanc_pkg::TANC_TBL_FETCH;
            nvm_fetch_ff <= 1'b1;
            nvm_addr_ff  <= acc_addr; // [R16]
          end
        end
        default: begin
          tbl_st_ff    <= tanc_pkg::TANC_TBL_IDLE;
          nvm_fetch_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_ff <= 8'h0;
    end else if (tbl_st_ff == tanc_pkg::TANC_TBL_FETCH) begin
      latch_ff <= nvm_addr_ff[0] ? nvm_rdata[15:8] : nvm_rdata[7:0]; // [R13] [R20]
    end else if (wr_ev && paddr == `TANC_OFF_LATCH) begin
      latch_ff <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // holding registers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < HOLD_BYTES; i++) begin : g_hold
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hold_ff[i] <= `TANC_HOLD_RST; // [R22]
      end else if (hold_clr) begin
        hold_ff[i] <= `TANC_HOLD_RST; // [R22]
      end else if (st_ev && acc_addr[HOLD_IDX-1:0] == HOLD_IDX'(i)) begin
        hold_ff[i] <= latch_ff; // [R17]
      end
    end
    assign hold_data[i*8 +: 8] = hold_ff[i];
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata     = prdata_ff;
  assign pready     = pready_ff;
  assign pslverr    = pslverr_ff;
  assign nvm_addr   = nvm_addr_ff;
  assign nvm_fetch  = nvm_fetch_ff;
  assign ee_read    = fetch_bit_ff;
  assign cyc_active = launch_ff;
  assign cyc_erase  = cyc_erase_ff;
  assign cyc_space  = cyc_space_ff;
  assign cyc_addr   = cyc_addr_ff;
  assign cpu_stall  = stall_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  unlock_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
    (nxt_pready && !pwrite && paddr == `TANC_OFF_UNLOCK) |=> prdata_ff == 32'h0)
    else $error("unlock port read not zero");
  ctrl_bit5_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    (nxt_pready && !pwrite && paddr == `TANC_OFF_CTRL) |=> !prdata_ff[5])
    else $error("control bit 5 not zero");
  launch_fault_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
    launch_ok |=> fault_ff && launch_ff && cnt_ff == CNT_W'(CYC_CYCLES))
    else $error("launch did not set fault and cycle");
  cycle_end_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
    cyc_done |=> !launch_ff && done_ff && !fault_ff && !stall_ff)
    else $error("cycle end did not finish cleanly");
  permit_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (w_launch && !permit_ff) |=> !launch_ff && fault_ff)
    else $error("launch passed without permit");
  busy_ignore_a: assert property (@(posedge pclk) disable iff (!presetn) // [R24]
    (launch_ff && !cyc_done && hit_ctrl) |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
    else $error("running cycle restarted");
  fetch_block_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
    (hit_ctrl && (space_ff || cfg_ff)) |=> !fetch_bit_ff ##1 !fetch_bit_ff)
    else $error("eeprom fetch not blocked");
  fetch_byte_a: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
    (tbl_st_ff == tanc_pkg::TANC_TBL_FETCH) |=>
      latch_ff == ($past(nvm_addr_ff[0]) ? $past(nvm_rdata[15:8]) : $past(nvm_rdata[7:0])))
    else $error("fetched byte wrong");
  ptr_top_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
    tbl_go |=> ptr_ff[21] == $past(ptr_ff[21]))
    else $error("pointer top bit changed by update");
  stall_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
    (launch_ok && space_ff) |=> stall_ff && !pready_ff)
    else $error("core not stalled in flash cycle");

endmodule : tanc_nvm_ctrl

//--- test/tanc_nvm_model.sv
`timescale 1ns/1ns
module tanc_nvm_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        nvm_fetch,
  input  wire logic [21:0] nvm_addr,
  output wire logic [15:0] nvm_rdata
);
  logic [15:0] idle_ff;

  // ----------------------------------------------------------------
  // array word, high byte differs from low byte
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_ff <= 16'hA5A5;
    end else begin
      idle_ff <= ~idle_ff ^ 16'h0F0F;
    end
  end

  // word valid only in the fetch cycle, a changing pattern otherwise
  assign nvm_rdata = nvm_fetch ? {nvm_addr[8:1] ^ 8'hC3, nvm_addr[8:1]} : idle_ff;
endmodule : tanc_nvm_model

//--- test/tb.sv
`timescale 1ns/1ns
`include "tanc_nvm_defs.svh"
module tb;
  localparam int CYC   = 20;
  localparam int LIMIT = 20000;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [15:0]  nvm_rdata;
  logic [21:0]  nvm_addr, cyc_addr, fet_addr, ptr, a;
  logic         nvm_fetch, ee_read, cyc_active, cyc_erase, cpu_stall;
  logic [1:0]   cyc_space;
  logic [511:0] hold_data;
  int           n_fail, tests_run, cycles, act_n, fet_n, ee_n;
  logic [7:0]   lc [5] = '{8'h04, 8'h84, 8'h44, 8'hC4, 8'h94};
  logic [1:0]   ls [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1};

  tanc_nvm_ctrl #(.HOLD_BYTES(64), .CYC_CYCLES(CYC)) tanc_nvm_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_rdata(nvm_rdata), .nvm_addr(nvm_addr), .nvm_fetch(nvm_fetch), .ee_read(ee_read),
    .cyc_active(cyc_active), .cyc_erase(cyc_erase), .cyc_space(cyc_space),
    .cyc_addr(cyc_addr), .hold_data(hold_data), .cpu_stall(cpu_stall));
  tanc_nvm_model tanc_nvm_model_inst (
    .pclk(pclk), .presetn(presetn), .nvm_fetch(nvm_fetch), .nvm_addr(nvm_addr),
    .nvm_rdata(nvm_rdata));

  // ----------------------------------------------------------------
  // clock, event counters, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cyc_active === 1'b1) act_n++;
    if (ee_read === 1'b1) ee_n++;
    if (nvm_fetch === 1'b1) begin
      fet_n++;
      fet_addr = nvm_addr;
    end
    if (cycles == LIMIT) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    if (n >= 300) chk(0, 1, "no answer");
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask : wr
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp, what);
  endtask : rchk
  task automatic set_ptr(input logic [21:0] p);
    wr(`TANC_OFF_PTRL, 32'(p[7:0]));
    wr(`TANC_OFF_PTRH, 32'(p[15:8]));
    wr(`TANC_OFF_PTRU, 32'(p[21:16]));
  endtask : set_ptr
  function automatic logic [7:0] exp_byte(input logic [21:0] x);
    exp_byte = x[0] ? (x[8:1] ^ 8'hC3) : x[8:1];
  endfunction : exp_byte

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(32'(hold_data === {64{8'hFF}}), 1, "hold reset");
    chk(32'({cyc_active, cpu_stall, nvm_fetch, ee_read}), 0, "idle outputs");
    rchk(`TANC_OFF_CTRL, 0, "ctrl reset");
    wr(`TANC_OFF_UNLOCK, 32'h55);
    rchk(`TANC_OFF_UNLOCK, 0, "unlock read");
    rchk(8'h20, 0, "unmapped read");
    chk(32'(err), 1, "unmapped error");
  endtask : t_reset
  task automatic t_ctrl();
    wr(`TANC_OFF_CTRL, 32'hF4);
    rchk(`TANC_OFF_CTRL, 32'hD4, "ctrl fields");
    ee_n = 0;
    wr(`TANC_OFF_CTRL, 32'h81);
    rchk(`TANC_OFF_CTRL, 32'h80, "fetch blocked");
    chk(32'(ee_n), 0, "no ee read");
    wr(`TANC_OFF_CTRL, 32'h00);
    wr(`TANC_OFF_CTRL, 32'h01);
    rchk(`TANC_OFF_CTRL, 32'h00, "fetch self clear");
    chk(32'(ee_n), 1, "one ee read");
  endtask : t_ctrl
  task automatic t_table();
    logic [1:0] m;
    ptr = 22'h3F_FFFF;
    set_ptr(ptr);
    for (int i = 1; i <= 4; i++) begin
      m = 2'(i % 4);
      a = ptr;
      if (m == 2'h1) ptr = {ptr[21], ptr[20:0] + 21'h1};
      if (m == 2'h2) ptr = {ptr[21], ptr[20:0] - 21'h1};
      if (m == 2'h3) ptr = {ptr[21], ptr[20:0] + 21'h1};
      if (m == 2'h3) a = ptr;
      fet_n = 0;
      wr(`TANC_OFF_CMD, 32'(m));
      repeat (3) @(posedge pclk);
      chk(32'(fet_n), 1, "one fetch");
      chk(32'(fet_addr), 32'(a), "fetch addr");
      rchk(`TANC_OFF_LATCH, 32'(exp_byte(a)), "latch byte");
      rchk(`TANC_OFF_PTRL, 32'(ptr[7:0]), "ptr low");
      rchk(`TANC_OFF_PTRH, 32'(ptr[15:8]), "ptr high");
      rchk(`TANC_OFF_PTRU, 32'(ptr[21:16]), "ptr upper");
    end
  endtask : t_table
  task automatic t_store();
    wr(`TANC_OFF_LATCH, 32'h5A);
    ptr = 22'h3F_FFC5;
    set_ptr(ptr);
    wr(`TANC_OFF_CMD, 32'h4);
    @(posedge pclk);
    chk(32'(hold_data[47:40]), 32'h5A, "stored byte");
    chk(32'(hold_data[39:32]), 32'hFF, "other byte");
  endtask : t_store
  task automatic t_launch(input logic [7:0] c, input logic [1:0] sp);
    int n;
    wr(`TANC_OFF_CTRL, 32'(c));
    wr(`TANC_OFF_UNLOCK, 32'h55);
    wr(`TANC_OFF_UNLOCK, 32'hAA);
    act_n = 0;
    wr(`TANC_OFF_CTRL, 32'(c | 8'h02));
    repeat (2) @(posedge pclk);
    chk(32'(cyc_active), 1, "cycle start");
    chk(32'(cyc_space), 32'(sp), "space");
    chk(32'(cyc_erase), 32'(c[4]), "erase");
    chk(32'(cpu_stall), 32'(sp != 2'h0), "stall");
    a = (sp != 2'h0) ? {ptr[21:6], 6'h00} : ptr;
    chk(32'(cyc_addr), 32'(a), "cycle addr");
    if (sp == 2'h0) begin
      wr(`TANC_OFF_UNLOCK, 32'h55);
      wr(`TANC_OFF_UNLOCK, 32'hAA);
      wr(`TANC_OFF_CTRL, 32'(c | 8'h0A));
      rchk(`TANC_OFF_CTRL, 32'(c | 8'h0A), "running");
    end
    n = 0;
    while (cyc_active !== 1'b0 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(act_n), CYC, "cycle length");
    rchk(`TANC_OFF_CTRL, 32'(c & 8'hEF), "ctrl after");
    if (sp != 2'h0) chk(32'(hold_data === {64{8'hFF}}), 1, "hold cleared");
    apb(1'b0, `TANC_OFF_STAT, 32'h0);
    chk(rd & 32'h3, 1, "done set");
    apb(1'b0, `TANC_OFF_STAT, 32'h0);
    chk(rd & 32'h3, 1, "done held");
    wr(`TANC_OFF_STAT, 32'h1);
    apb(1'b0, `TANC_OFF_STAT, 32'h0);
    chk(rd & 32'h3, 0, "done cleared");
  endtask : t_launch
  task automatic t_fault();
    act_n = 0;
    wr(`TANC_OFF_CTRL, 32'h84);
    wr(`TANC_OFF_CTRL, 32'h86);
    rchk(`TANC_OFF_CTRL, 32'h8C, "no unlock");
    wr(`TANC_OFF_CTRL, 32'h80);
    wr(`TANC_OFF_UNLOCK, 32'h55);
    wr(`TANC_OFF_UNLOCK, 32'hAA);
    wr(`TANC_OFF_CTRL, 32'h82);
    rchk(`TANC_OFF_CTRL, 32'h88, "no permit");
    chk(32'(act_n), 0, "no cycle");
  endtask : t_fault

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctrl();
    t_table();
    t_store();
    for (int i = 0; i < 5; i++) t_launch(lc[i], ls[i]);
    t_fault();
    conclude();
  end
endmodule : tb
